/* verilog/dib_integrate.sv */
/*
  Digital integration output stage: region accumulation, result buffer,
  saturation check and the configuration registers of the analog path.
  Assumes a 200 MHz clock, inputs synchronous to it, a serial register
  front end that issues single-cycle read and write strobes, and a
  converter that returns one sample per conversion request.
*/
`timescale 1ns/1ps

module dib_integrate
  import dib_pkg::*;
#(
  parameter int CONV_CYCLES = DIB_CONV_CYCLES
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             arst_n_i,
  // register port
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [15:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [15:0]      reg_rdata_o,
  output logic                  reg_rvalid_o,
  // slot timing
  input  wire logic             slot_start_i,
  input  wire logic             slot_b_i,
  input  wire dib_slot_timing_t timing_a_i,
  input  wire dib_slot_timing_t timing_b_i,
  // converter
  output logic                  conv_start_o,
  input  wire logic             conv_valid_i,
  input  wire logic [13:0]      conv_sample_i,
  // analog path steering
  output dib_fe_ctl_t           fe_ctl_a_o,
  output dib_fe_ctl_t           fe_ctl_b_o,
  // result stream toward the fifo
  output logic                  res_valid_o,
  input  wire logic             res_ready_i,
  output dib_result_t           res_data_o,
  output logic                  res_busy_o
);

  typedef enum logic [2:0] {
    DIB_IDLE = 3'b001,
    DIB_RUN  = 3'b010,
    DIB_HOLD = 3'b100
  } dib_state_t;

  logic [15:0] slot_en_q, mode_a_q, path_a_q, mode_b_q, path_b_q;
  logic [15:0] conv_clk_q, int_en_q, int_cfg_q;
  logic [31:0] dark_a_q, dark_b_q;
  dib_state_t  state_q;
  logic        slot_b_q, dbl_q;
  logic [15:0] cnt_q;
  logic [31:0] neg_q, pos_q;
  dib_result_t pend_q, spare_q;
  logic        spare_v_q;
  logic [7:0]  div_q;

  // sampling config is masked by the per-slot enable
  function automatic logic slot_enabled(input logic [15:0] en, input logic b);
    return b ? en[DIB_INT_EN_B_BIT] : en[DIB_INT_EN_A_BIT];
  endfunction

  // region of sample k: 1 = negative, 2 = positive, 0 = outside
  function automatic logic [1:0] region_of(input logic [15:0] k, input logic [7:0] ofs,
                                          input logic [7:0] w, input logic dbl);
    logic [15:0] base;
    logic [15:0] ww;
    base = {8'h00, ofs} + {8'h00, DIB_REGION_LEAD};
    ww   = {8'h00, w};
    if (k < base || ww == 16'h0000) begin
      return 2'h0;
    end else if (k < base + ww) begin
      return 2'h1;
    end else if (k < base + (dbl ? 16'(ww * 3) : 16'(ww * 2))) begin
      return 2'h2;
    end else if (dbl && k < base + 16'(ww * 4)) begin
      return 2'h1;
    end
    return 2'h0;
  endfunction

  function automatic logic [15:0] window_end(input logic [7:0] ofs, input logic [7:0] w, input logic dbl);
    return {8'h00, ofs} + {8'h00, DIB_REGION_LEAD} + (dbl ? 16'({8'h00, w} * 4) : 16'({8'h00, w} * 2));
  endfunction

  // zero divisors read as one so the check never divides by zero
  function automatic logic sat_check(input logic signed [31:0] net, input logic [31:0] dark,
                                     input dib_slot_timing_t t, input logic dbl);
    logic signed [33:0] rw, lw, mn, np, val;
    rw  = dbl ? 34'(t.width) * 2 : 34'(t.width);
    lw  = 34'(t.pulse_width);
    mn  = (lw < rw) ? lw : rw;
    np  = 34'(t.pulses);
    if (rw == 34'sd0) rw = 34'sd1;
    if (mn == 34'sd0) mn = 34'sd1;
    if (np == 34'sd0) np = 34'sd1;
    val = (34'(net) / mn + $signed({2'b00, dark}) / rw) / np;
    return val > DIB_SAT_LIMIT;
  endfunction

  function automatic dib_fe_ctl_t fe_decode(input logic [15:0] mode, input logic [15:0] path);
    dib_fe_ctl_t c;
    c.buffer_mode = (mode[DIB_FE_MODE_LSB +: 8] == DIB_FE_BUFFER);
    c.normal_path = (path == DIB_PATH_NORMAL);
    c.bpf_bypass  = (path == DIB_PATH_NO_BPF) || (path == DIB_PATH_NO_INT);
    c.int_bypass  = (path == DIB_PATH_NO_INT);
    return c;
  endfunction

  dib_slot_timing_t cur_t;
  logic [1:0]       region;
  logic [2:0]       fifo_sel;
  logic             push, take;

  always_comb begin
    cur_t    = slot_b_q ? timing_b_i : timing_a_i;
    region   = region_of(cnt_q, cur_t.offset, cur_t.width, dbl_q);
    fifo_sel = slot_b_q ? slot_en_q[DIB_FIFO_SEL_B_LSB +: 3] : slot_en_q[DIB_FIFO_SEL_A_LSB +: 3];
    take     = !res_valid_o || res_ready_i;
    push     = (state_q == DIB_HOLD) && !spare_v_q;
  end

  // register writes
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slot_en_q  <= DIB_RST_SLOT_EN;
      mode_a_q   <= DIB_RST_ZERO;
      path_a_q   <= DIB_RST_ZERO;
      mode_b_q   <= DIB_RST_ZERO;
      path_b_q   <= DIB_RST_ZERO;
      conv_clk_q <= DIB_RST_ZERO;
      int_en_q   <= DIB_RST_ZERO;
      int_cfg_q  <= DIB_RST_ZERO;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        DIB_OFS_SLOT_EN:   slot_en_q  <= reg_wdata_i;
        DIB_OFS_A_FE_MODE: mode_a_q   <= reg_wdata_i;
        DIB_OFS_A_FE_PATH: path_a_q   <= reg_wdata_i;
        DIB_OFS_B_FE_MODE: mode_b_q   <= reg_wdata_i;
        DIB_OFS_B_FE_PATH: path_b_q   <= reg_wdata_i;
        DIB_OFS_CONV_CLK:  conv_clk_q <= reg_wdata_i;
        DIB_OFS_INT_EN:    int_en_q   <= reg_wdata_i;
        DIB_OFS_INT_CFG:   int_cfg_q  <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // register reads, unmapped offsets answer zero
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o  <= DIB_RST_ZERO;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          DIB_OFS_SLOT_EN:   reg_rdata_o <= slot_en_q;
          DIB_OFS_A_FE_MODE: reg_rdata_o <= mode_a_q;
          DIB_OFS_A_FE_PATH: reg_rdata_o <= path_a_q;
          DIB_OFS_B_FE_MODE: reg_rdata_o <= mode_b_q;
          DIB_OFS_B_FE_PATH: reg_rdata_o <= path_b_q;
          DIB_OFS_CONV_CLK:  reg_rdata_o <= conv_clk_q;
          DIB_OFS_INT_EN:    reg_rdata_o <= int_en_q;
          DIB_OFS_INT_CFG:   reg_rdata_o <= int_cfg_q;
          DIB_OFS_A_DARK_0:  reg_rdata_o <= dark_a_q[15:0];
          DIB_OFS_A_DARK_1:  reg_rdata_o <= dark_a_q[15:0];
          DIB_OFS_A_DARK_2:  reg_rdata_o <= dark_a_q[31:16];
          DIB_OFS_B_DARK_0:  reg_rdata_o <= dark_b_q[15:0];
          DIB_OFS_B_DARK_1:  reg_rdata_o <= dark_b_q[15:0];
          DIB_OFS_B_DARK_2:  reg_rdata_o <= dark_b_q[31:16];
          default:           reg_rdata_o <= DIB_RST_ZERO;
        endcase
      end
    end
  end

  // analog path steering, registered so outputs come from flops
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fe_ctl_a_o <= '0;
      fe_ctl_b_o <= '0;
    end else begin
      fe_ctl_a_o <= fe_decode(mode_a_q, path_a_q);
      fe_ctl_b_o <= fe_decode(mode_b_q, path_b_q);
    end
  end

  // conversion request every microsecond while a window runs
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q        <= 8'h00;
      conv_start_o <= 1'b0;
    end else if (state_q != DIB_RUN) begin
      div_q        <= 8'h00;
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= (div_q == 8'h00);
      div_q        <= (div_q == 8'(CONV_CYCLES - 1)) ? 8'h00 : div_q + 8'h01;
    end
  end

  // accumulation engine; a new slot is refused while a result waits in DIB_HOLD for the spare entry
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q  <= DIB_IDLE;
      slot_b_q <= 1'b0;
      dbl_q    <= 1'b0;
      cnt_q    <= 16'h0000;
      neg_q    <= 32'h0000_0000;
      pos_q    <= 32'h0000_0000;
      pend_q   <= '0;
      dark_a_q <= 32'h0000_0000;
      dark_b_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        DIB_IDLE: begin
          if (slot_start_i && slot_enabled(int_en_q, slot_b_i)) begin
            state_q  <= DIB_RUN;
            slot_b_q <= slot_b_i;
            // single pair bit set means single; only read here, inside the mode
            dbl_q    <= !(slot_b_i ? int_cfg_q[DIB_SINGLE_B_BIT] : int_cfg_q[DIB_SINGLE_A_BIT]);
            cnt_q    <= 16'h0000;
            neg_q    <= 32'h0000_0000;
            pos_q    <= 32'h0000_0000;
          end
        end
        DIB_RUN: begin
          if (conv_valid_i) begin
            cnt_q <= cnt_q + 16'h0001;
            if (region == 2'h1) neg_q <= neg_q + {18'h00000, conv_sample_i};
            if (region == 2'h2) pos_q <= pos_q + {18'h00000, conv_sample_i};
          end
          if (cnt_q >= window_end(cur_t.offset, cur_t.width, dbl_q)) begin
            state_q                <= DIB_HOLD;
            pend_q.slot_b          <= slot_b_q;
            pend_q.wide            <= (fifo_sel == DIB_FIFO_SEL_32);
            pend_q.dark_region_sum <= neg_q;
            pend_q.net_pulse_value <= $signed(pos_q - neg_q);
            pend_q.saturated       <= sat_check($signed(pos_q - neg_q), neg_q, cur_t, dbl_q);
            if (slot_b_q) dark_b_q <= neg_q;
            else          dark_a_q <= neg_q;
            if (fifo_sel != DIB_FIFO_SEL_16 && fifo_sel != DIB_FIFO_SEL_32) state_q <= DIB_IDLE;
          end
        end
        DIB_HOLD: begin
          if (push) state_q <= DIB_IDLE;
        end
        default: state_q <= DIB_IDLE;
      endcase
    end
  end

  // two-entry buffer: output register plus one spare
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      res_valid_o <= 1'b0;
      res_data_o  <= '0;
      spare_q     <= '0;
      spare_v_q   <= 1'b0;
      res_busy_o  <= 1'b0;
    end else begin
      res_busy_o <= (state_q != DIB_IDLE) || spare_v_q;
      if (take) begin
        if (spare_v_q) begin
          res_data_o  <= spare_q;
          res_valid_o <= 1'b1;
          spare_v_q   <= push;
          if (push) spare_q <= pend_q;
        end else begin
          res_valid_o <= push;
          if (push) res_data_o <= pend_q;
        end
      end else if (push) begin
        spare_q   <= pend_q;
        spare_v_q <= 1'b1;
      end
    end
  end

endmodule

/* verilog/dib_pkg.sv */
/*
  Shared definitions for the digital integration output stage:
  register offsets, field positions, reset values, mode codes and the
  structs carried between the stage and its surroundings.
  Assumes a 16-bit register port and a 14-bit converter sample.
*/
package dib_pkg;

  // register offsets
  localparam logic [7:0] DIB_OFS_SLOT_EN     = 8'h11;
  localparam logic [7:0] DIB_OFS_A_FE_MODE   = 8'h42;
  localparam logic [7:0] DIB_OFS_A_FE_PATH   = 8'h43;
  localparam logic [7:0] DIB_OFS_B_FE_MODE   = 8'h44;
  localparam logic [7:0] DIB_OFS_B_FE_PATH   = 8'h45;
  localparam logic [7:0] DIB_OFS_CONV_CLK    = 8'h4E;
  localparam logic [7:0] DIB_OFS_INT_EN      = 8'h58;
  localparam logic [7:0] DIB_OFS_INT_CFG     = 8'h5A;
  localparam logic [7:0] DIB_OFS_A_DARK_0    = 8'h65;
  localparam logic [7:0] DIB_OFS_A_DARK_1    = 8'h71;
  localparam logic [7:0] DIB_OFS_A_DARK_2    = 8'h75;
  localparam logic [7:0] DIB_OFS_B_DARK_0    = 8'h69;
  localparam logic [7:0] DIB_OFS_B_DARK_1    = 8'h79;
  localparam logic [7:0] DIB_OFS_B_DARK_2    = 8'h7D;

  // field positions
  localparam int DIB_FIFO_SEL_A_LSB  = 2;
  localparam int DIB_FIFO_SEL_B_LSB  = 6;
  localparam int DIB_FE_MODE_LSB     = 8;
  localparam int DIB_INT_EN_A_BIT    = 12;
  localparam int DIB_INT_EN_B_BIT    = 13;
  localparam int DIB_SINGLE_A_BIT    = 5;
  localparam int DIB_SINGLE_B_BIT    = 6;

  // reset values
  localparam logic [15:0] DIB_RST_SLOT_EN = 16'h1000;
  localparam logic [15:0] DIB_RST_ZERO    = 16'h0000;

  // mode codes
  localparam logic [2:0]  DIB_FIFO_SEL_16   = 3'h3;
  localparam logic [2:0]  DIB_FIFO_SEL_32   = 3'h4;
  localparam logic [7:0]  DIB_FE_NORMAL     = 8'h1C;
  localparam logic [7:0]  DIB_FE_BUFFER     = 8'h1D;
  localparam logic [15:0] DIB_PATH_NORMAL   = 16'hADA5;
  localparam logic [15:0] DIB_PATH_NO_BPF   = 16'hAE65;
  localparam logic [15:0] DIB_PATH_NO_INT   = 16'hB065;

  // timing
  localparam int DIB_CLK_MHZ          = 200;
  localparam int DIB_CONV_PERIOD_US   = 1;
  localparam int DIB_CONV_CYCLES      = DIB_CONV_PERIOD_US * DIB_CLK_MHZ;
  localparam logic [7:0] DIB_REGION_LEAD = 8'h09;
  localparam logic signed [33:0] DIB_SAT_LIMIT = 34'sh0_0000_3FFF;

  // per-slot timing, supplied by the timing core
  typedef struct packed {
    logic [7:0] offset;
    logic [7:0] width;
    logic [7:0] pulse_width;
    logic [7:0] pulses;
  } dib_slot_timing_t;

  // analog path steering for one slot
  typedef struct packed {
    logic buffer_mode;
    logic normal_path;
    logic bpf_bypass;
    logic int_bypass;
  } dib_fe_ctl_t;

  // one result pair, dark and net from the same sample
  typedef struct packed {
    logic               slot_b;
    logic               wide;
    logic               saturated;
    logic [31:0]        dark_region_sum;
    logic signed [31:0] net_pulse_value;
  } dib_result_t;

endpackage

/* testbench/dib_integrate_monitor.sv */
/*
  Port-level assertions for the digital integration stage.
  Assumes the bench sets CONV_CYCLES to 4 and spaces writes to one register.
*/
`timescale 1ns/1ps
module dib_integrate_monitor
  import dib_pkg::*;
#(
  parameter int CONV_CYCLES = 4
) (
  // clock and reset
  input wire logic             clk_sys_i,
  input wire logic             arst_n_i,
  // register port
  input wire logic [7:0]       reg_addr_i,
  input wire logic [15:0]      reg_wdata_i,
  input wire logic             reg_wr_i,
  input wire logic             reg_rd_i,
  input wire logic [15:0]      reg_rdata_o,
  input wire logic             reg_rvalid_o,
  // slot timing and converter
  input wire logic             slot_start_i,
  input wire logic             slot_b_i,
  input wire dib_slot_timing_t timing_a_i,
  input wire dib_slot_timing_t timing_b_i,
  input wire logic             conv_start_o,
  input wire logic             conv_valid_i,
  input wire logic [13:0]      conv_sample_i,
  // steering and results
  input wire dib_fe_ctl_t      fe_ctl_a_o,
  input wire dib_fe_ctl_t      fe_ctl_b_o,
  input wire logic             res_valid_o,
  input wire logic             res_ready_i,
  input wire dib_result_t      res_data_o,
  input wire logic             res_busy_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe not answered");
  rd_only_a: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("read answer without strobe");
  unmapped_zero_a: assert property (reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  mode_buf_a: assert property (reg_wr_i && reg_addr_i == DIB_OFS_A_FE_MODE |-> ##2
    fe_ctl_a_o.buffer_mode == ($past(reg_wdata_i[15:8], 2) == DIB_FE_BUFFER))
    else $error("slot a buffer mode wrong");
  path_a_a: assert property (reg_wr_i && reg_addr_i == DIB_OFS_A_FE_PATH |-> ##2
    fe_ctl_a_o.normal_path == ($past(reg_wdata_i, 2) == DIB_PATH_NORMAL)
    && fe_ctl_a_o.int_bypass == ($past(reg_wdata_i, 2) == DIB_PATH_NO_INT))
    else $error("slot a path steering wrong");
  path_b_a: assert property (reg_wr_i && reg_addr_i == DIB_OFS_B_FE_PATH |-> ##2
    fe_ctl_b_o.bpf_bypass == ($past(reg_wdata_i, 2) == DIB_PATH_NO_BPF || $past(reg_wdata_i, 2) == DIB_PATH_NO_INT))
    else $error("slot b filter bypass wrong");
  res_hold_a: assert property (res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_data_o))
    else $error("result changed while stalled");
  conv_gap_a: assert property (conv_start_o |=> !conv_start_o [*3])
    else $error("conversions closer than period");
  conv_busy_a: assert property (conv_start_o |-> res_busy_o)
    else $error("conversion outside a window");

  cover property (res_valid_o && !res_ready_i);
  cover property (res_valid_o && res_ready_i);
  cover property (res_valid_o && res_data_o.saturated);
endmodule

/* testbench/dib_conv_model.sv */
/*
  Converter model: answers each conversion request after a set delay.
  Assumes the bench clears its sample index at every slot start.
*/
`timescale 1ns/1ps
module dib_conv_model (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  // control from the bench and the stage
  input  wire logic        start_i,
  input  wire logic        clr_i,
  input  wire logic [1:0]  dly_i,
  input  wire logic [13:0] lo_i,
  input  wire logic [13:0] hi_i,
  input  wire logic [7:0]  edge_i,
  // conversion result
  output logic             valid_o,
  output logic [13:0]      sample_o
);
  logic [7:0] n_q;
  logic [1:0] cnt_q;
  logic       pend_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      n_q      <= 8'h00;
      cnt_q    <= 2'h0;
      pend_q   <= 1'b0;
      valid_o  <= 1'b0;
      sample_o <= 14'h0000;
    end else begin
      valid_o  <= 1'b0;
      // data line is not held outside the strobe
      sample_o <= ~sample_o;
      if (clr_i) n_q <= 8'h00;
      if (start_i) begin
        pend_q <= 1'b1;
        cnt_q  <= dly_i;
      end else if (pend_q) begin
        if (cnt_q == 2'h0) begin
          pend_q   <= 1'b0;
          valid_o  <= 1'b1;
          sample_o <= (n_q >= edge_i) ? hi_i : lo_i;
          n_q      <= n_q + 8'h01;
        end else begin
          cnt_q <= cnt_q - 2'h1;
        end
      end
    end
  end
endmodule

/* testbench/tb_top.sv */
/*
  Self-checking bench for the digital integration stage.
  Assumes the converter model and a shortened conversion period of 4 cycles.
*/
`timescale 1ns/1ps
module tb_top
  import dib_pkg::*;
;
  localparam int CONV_CYCLES = 4;
  // channel offsets are the host's duty; the stage must leave its sums alone
  localparam logic [7:0]  CH_OFS_FIRST = 8'h18;
  localparam logic [7:0]  CH_OFS_LAST  = 8'h21;
  localparam logic [15:0] CH_OFS_HEAD  = 16'h1F00;
  localparam logic [15:0] PATHS [3] = '{DIB_PATH_NORMAL, DIB_PATH_NO_BPF, DIB_PATH_NO_INT};
  logic             clk_sys_i, arst_n_i, reg_wr_i, reg_rd_i, slot_start_i, slot_b_i, res_ready_i;
  logic             conv_valid_i, conv_start_o, reg_rvalid_o, res_valid_o, res_busy_o, e_sat;
  logic [7:0]       reg_addr_i, edge_q;
  logic [15:0]      reg_wdata_i, reg_rdata_o;
  logic [13:0]      conv_sample_i, lo_q, hi_q;
  logic [1:0]       dly_q;
  logic [31:0]      e_dark, e_net;
  dib_slot_timing_t timing_a_i, timing_b_i;
  dib_fe_ctl_t      fe_ctl_a_o, fe_ctl_b_o;
  dib_result_t      res_data_o;
  int               fails, n_checks, cyc;

  dib_integrate #(.CONV_CYCLES(CONV_CYCLES)) DUT (.clk_sys_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .slot_start_i, .slot_b_i, .timing_a_i, .timing_b_i, .conv_start_o,
    .conv_valid_i, .conv_sample_i, .fe_ctl_a_o, .fe_ctl_b_o, .res_valid_o, .res_ready_i, .res_data_o, .res_busy_o);
  dib_conv_model u_conv (.clk_sys_i, .arst_n_i, .start_i(conv_start_o), .clr_i(slot_start_i), .dly_i(dly_q),
    .lo_i(lo_q), .hi_i(hi_q), .edge_i(edge_q), .valid_o(conv_valid_i), .sample_o(conv_sample_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // whole run needs well under a thousand cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {16'h0, e}, {16'h0, reg_rdata_o});
    chk("read valid", 32'h1, {31'h0, reg_rvalid_o});
  endtask

  task automatic poke(input logic sb);
    @(posedge clk_sys_i);
    slot_b_i     <= sb;
    slot_start_i <= 1'b1;
    @(posedge clk_sys_i);
    slot_start_i <= 1'b0;
  endtask

  // expected sums walked sample by sample over the regions
  function automatic void calc(input logic sgl, input dib_slot_timing_t t);
    logic [31:0] pos;
    int b, m, s;
    b = t.offset + 9;
    m = sgl ? 1 : 2;
    pos = 0;
    e_dark = 0;
    for (int k = 0; k < b + 2 * m * t.width; k++) begin
      s = (k >= edge_q) ? hi_q : lo_q;
      if ((k >= b && k < b + t.width) || (!sgl && k >= b + 3 * t.width)) e_dark += s;
      else if (k >= b + t.width) pos += s;
    end
    e_net = pos - e_dark;
    e_sat = ((e_net / ((t.pulse_width < m * t.width) ? t.pulse_width : m * t.width)) + e_dark / (m * t.width))
            / t.pulses > 32'h3FFF;
  endfunction

  task automatic run(input logic sb, input logic sgl, input logic wide);
    int i;
    calc(sgl, sb ? timing_b_i : timing_a_i);
    poke(sb);
    i = 0;
    while (res_valid_o !== 1'b1 && i < 2000) begin
      @(posedge clk_sys_i);
      #1;
      i++;
    end
    chk("dark sum", e_dark, res_data_o.dark_region_sum);
    chk("net value", e_net, res_data_o.net_pulse_value);
    chk("saturated", {31'h0, e_sat}, {31'h0, res_data_o.saturated});
    chk("slot and width", {30'h0, sb, wide}, {30'h0, res_data_o.slot_b, res_data_o.wide});
    repeat (3) @(posedge clk_sys_i);
    res_ready_i <= 1'b1;
    @(posedge clk_sys_i);
    res_ready_i <= 1'b0;
    #1;
    chk("valid after take", 32'h0, {31'h0, res_valid_o});
    rc(sb ? DIB_OFS_B_DARK_0 : DIB_OFS_A_DARK_0, e_dark[15:0]);
    rc(sb ? DIB_OFS_B_DARK_1 : DIB_OFS_A_DARK_1, e_dark[15:0]);
    rc(sb ? DIB_OFS_B_DARK_2 : DIB_OFS_A_DARK_2, e_dark[31:16]);
  endtask

  initial begin
    logic [7:0]  md;
    logic [15:0] p;
    fails = 0;
    n_checks = 0;
    cyc = 0;
    arst_n_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 16'h0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    slot_start_i = 1'b0;
    slot_b_i = 1'b0;
    res_ready_i = 1'b0;
    dly_q = 2'h1;
    lo_q = 14'h0100;
    hi_q = 14'h0200;
    edge_q = 8'h0A;
    timing_a_i = {8'h00, 8'h02, 8'h02, 8'h01};
    timing_b_i = {8'h01, 8'h02, 8'h01, 8'h01};
    repeat (6) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rc(DIB_OFS_SLOT_EN, DIB_RST_SLOT_EN);
    rc(DIB_OFS_INT_EN, 16'h0000);
    rc(8'h00, 16'h0000);
    wr(DIB_OFS_A_DARK_0, 16'hFFFF);
    rc(DIB_OFS_A_DARK_0, 16'h0000);
    wr(DIB_OFS_CONV_CLK, 16'h0040);
    rc(DIB_OFS_CONV_CLK, 16'h0040);
    for (int i = 0; i < 3; i++) begin
      md = i[0] ? DIB_FE_NORMAL : DIB_FE_BUFFER;
      p = PATHS[i];
      wr(DIB_OFS_A_FE_MODE, {md, 8'h00});
      wr(DIB_OFS_B_FE_MODE, {md, 8'h00});
      wr(DIB_OFS_A_FE_PATH, p);
      wr(DIB_OFS_B_FE_PATH, p);
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk("steer a", {md == DIB_FE_BUFFER, p == DIB_PATH_NORMAL, p != DIB_PATH_NORMAL, p == DIB_PATH_NO_INT},
          fe_ctl_a_o);
      chk("steer b", {md == DIB_FE_BUFFER, p == DIB_PATH_NORMAL, p != DIB_PATH_NORMAL, p == DIB_PATH_NO_INT},
          fe_ctl_b_o);
      rc(DIB_OFS_B_FE_MODE, {md, 8'h00});
      rc(DIB_OFS_B_FE_PATH, p);
    end
    // starts must be refused while the slot is not enabled
    poke(1'b0);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("busy when disabled", 32'h0, {31'h0, res_busy_o});
    wr(DIB_OFS_INT_EN, 16'h1000);
    poke(1'b1);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("busy slot b off", 32'h0, {31'h0, res_busy_o});
    wr(DIB_OFS_SLOT_EN, 16'h100C);
    wr(DIB_OFS_INT_CFG, 16'h0020);
    rc(DIB_OFS_INT_CFG, 16'h0020);
    for (int c = CH_OFS_FIRST; c <= CH_OFS_LAST; c++) begin
      wr(8'(c), CH_OFS_HEAD);
    end
    run(1'b0, 1'b1, 1'b0);
    wr(DIB_OFS_SLOT_EN, 16'h110C);
    wr(DIB_OFS_INT_EN, 16'h3000);
    rc(DIB_OFS_INT_EN, 16'h3000);
    lo_q = 14'h0000;
    hi_q = 14'h3FFF;
    edge_q = 8'h0C;
    dly_q = 2'h2;
    run(1'b1, 1'b0, 1'b1);
    // selector 0 on slot a: nothing pushed, dark register still updates
    wr(DIB_OFS_SLOT_EN, 16'h1100);
    calc(1'b1, timing_a_i);
    poke(1'b0);
    repeat (80) @(posedge clk_sys_i);
    #1;
    chk("valid and busy sel 0", 32'h0, {30'h0, res_valid_o, res_busy_o});
    rc(DIB_OFS_A_DARK_0, e_dark[15:0]);
    wrap_up();
  end
endmodule

bind dib_integrate dib_integrate_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_mon (.clk_sys_i, .arst_n_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .slot_start_i, .slot_b_i, .timing_a_i,
  .timing_b_i, .conv_start_o, .conv_valid_i, .conv_sample_i, .fe_ctl_a_o, .fe_ctl_b_o, .res_valid_o,
  .res_ready_i, .res_data_o, .res_busy_o);
